// [inc/focp_defines.svh]
// Purpose: Named constants for the fanout output configuration port
// Assumes: 10-bit configuration word, bit index 0 holds the first-bank drive type
// Notes:   Shift order is most significant bit first
`ifndef FOCP_DEFINES_SVH
`define FOCP_DEFINES_SVH
`define FOCP_WORD_W        10
`define FOCP_OUT_N         8
`define FOCP_TYPE_A_BIT    0
`define FOCP_TYPE_BCD_BIT  1
`define FOCP_EN_LSB        2
`define FOCP_BANK_A_W      2
`define FOCP_CFG_RESET     10'h000
`define FOCP_TYPE_LVDS     1'b0
`define FOCP_CNT_W         4
`define FOCP_WORD_LEN      4'hA
`endif

// [inc/focp_pkg.sv]
// Purpose: Types for the fanout output configuration port
// Assumes: focp_defines.svh supplies widths
// Notes:   Config word struct mirrors the serial word layout
`include "focp_defines.svh"
package focp_pkg;
	typedef struct packed {
		logic [`FOCP_OUT_N-1:0] enables;
		logic                   bcd_banks_drive_type;
		logic                   first_bank_drive_type;
	} focp_cfg_s;
	typedef enum logic [1:0] {FOCP_UNCONF, FOCP_CONF} focp_state_e;
endpackage

// [rtl/focp_port.sv]
// Purpose: Serial configuration port and output control of a 1-to-8 fanout buffer
// Assumes: Link clock, data and strobe are asynchronous pins sampled by mclk
// Notes:   Outputs are per-output run enables and per-output drive type
//          Word length is not policed; the last ten bits shifted before the latch win
// Behaviour
// - Bit D1 sets bank A drive type and D2 sets banks B to D, low LVDS, high LVPECL.
// - Until a word is latched all outputs stay static with LVDS drive.
// - An output whose enable is inactive stays static.
// - The global enable input gates all eight outputs together.
// - The global enable input overrides the serial per-output enables.
// - The shift register contents are readable on the serial data output.
// - Global enable low disables all outputs, high lets each follow its bit.
// - The shifted word becomes active on the strobe rising; outputs keep running meanwhile.
`timescale 1ns/1ps
`include "focp_defines.svh"
module focp_port
	import focp_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   serial_clk,
	input  wire logic                   serial_in_line,
	input  wire logic                   config_latch_strobe,
	input  wire logic                   global_oe,
	output logic                        serial_out_line,
	output logic [`FOCP_OUT_N-1:0]      out_run,
	output logic [`FOCP_OUT_N-1:0]      out_lvpecl,
	output logic                        configured
);
	logic [2:0]              sclk_s_q;
	logic [2:0]              sdi_s_q;
	logic [2:0]              le_s_q;
	logic [2:0]              oe_s_q;
	logic                    sclk_lvl_q;
	logic                    le_lvl_q;
	logic                    oe_lvl_q;
	logic                    sdi_lvl_q;
	logic [`FOCP_WORD_W-1:0] shift_q;
	focp_cfg_s               active_q;
	focp_state_e             state_q;
	logic                    sclk_rise;
	logic                    le_rise;

	// Sampler stages two and three agree on the pin level
	function automatic logic focp_settled(input logic [2:0] s);
		return s[1] == s[2];
	endfunction

	// Three-stage samplers; a level counts once stages two and three agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s_q <= 3'h0;
			sdi_s_q  <= 3'h0;
			le_s_q   <= 3'h0;
			oe_s_q   <= 3'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], serial_clk};
			sdi_s_q  <= {sdi_s_q[1:0], serial_in_line};
			le_s_q   <= {le_s_q[1:0], config_latch_strobe};
			oe_s_q   <= {oe_s_q[1:0], global_oe};
		end
	end

	// Filtered levels move only while the last two stages agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_lvl_q <= 1'b0;
			le_lvl_q   <= 1'b0;
			oe_lvl_q   <= 1'b0;
			sdi_lvl_q  <= 1'b0;
		end else begin
			if (focp_settled(sclk_s_q))
				sclk_lvl_q <= sclk_s_q[2];
			if (focp_settled(le_s_q))
				le_lvl_q <= le_s_q[2];
			if (focp_settled(oe_s_q))
				oe_lvl_q <= oe_s_q[2];
			if (focp_settled(sdi_s_q))
				sdi_lvl_q <= sdi_s_q[2];
		end
	end

	// Edge pulses last one cycle; the filtered level serves as the previous value
	assign sclk_rise = focp_settled(sclk_s_q) && sclk_s_q[2] && !sclk_lvl_q;
	assign le_rise   = focp_settled(le_s_q) && le_s_q[2] && !le_lvl_q;

	// Shift register, MSB first; frozen while the strobe is high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= `FOCP_CFG_RESET;
		end else if (sclk_rise && !le_lvl_q) begin
			shift_q <= {shift_q[`FOCP_WORD_W-2:0], sdi_lvl_q};
		end
	end

	// Readback: MSB of the shift register drives the data output
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			serial_out_line <= 1'b0;
		else
			serial_out_line <= shift_q[`FOCP_WORD_W-1];
	end

	// Active word only changes on the strobe rising edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= `FOCP_CFG_RESET;
			state_q  <= FOCP_UNCONF;
		end else if (le_rise) begin
			active_q <= shift_q;
			state_q  <= FOCP_CONF;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			configured <= 1'b0;
		else
			configured <= (state_q == FOCP_CONF);
	end

	// Output gating: global enable overrides per-output bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_run <= '0;
		end else if (state_q != FOCP_CONF || !oe_lvl_q) begin
			out_run <= '0;
		end else begin
			out_run <= active_q.enables;
		end
	end

	// Drive type: bit index 0 for bank A pairs, bit index 1 for the rest
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_lvpecl <= '0;
		end else if (state_q != FOCP_CONF) begin
			out_lvpecl <= {`FOCP_OUT_N{`FOCP_TYPE_LVDS}};
		end else begin
			out_lvpecl <= {{(`FOCP_OUT_N-`FOCP_BANK_A_W){active_q.bcd_banks_drive_type}},
				{`FOCP_BANK_A_W{active_q.first_bank_drive_type}}};
		end
	end

	// Output gating and enable mapping
	a_oe_low_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!oe_lvl_q |=> out_run == '0)
		else $error("outputs run with global enable low");
	a_oe_priority: assert property (@(posedge mclk) disable iff (!rst_n)
		(out_run & ~$past(active_q.enables)) == '0)
		else $error("disabled output runs");
	a_oe_follow: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_CONF && oe_lvl_q |=> out_run == $past(active_q.enables))
		else $error("outputs ignore their enables");
	a_oe_rise_all: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(oe_lvl_q) && state_q == FOCP_CONF |=> out_run == $past(active_q.enables))
		else $error("global enable did not release all outputs");
	a_all_gate: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(oe_lvl_q) |=> out_run == '0 ##1 out_run == '0)
		else $error("global gate incomplete");
	a_enable_map: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_CONF && oe_lvl_q |=>
		out_run[`FOCP_OUT_N-1] == $past(active_q[`FOCP_WORD_W-1])
		&& out_run[0] == $past(active_q[`FOCP_EN_LSB]))
		else $error("enable bit map wrong");
	a_static_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!active_q.enables[0] ##1 !active_q.enables[0] |-> !out_run[0])
		else $error("disabled output toggles");
	a_off_steady: assert property (@(posedge mclk) disable iff (!rst_n)
		!oe_lvl_q ##1 !oe_lvl_q |=> $stable(out_run))
		else $error("gated outputs not static");

	// Start-up state and drive type
	a_unconf_lvds: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_UNCONF |=> out_lvpecl == '0 && out_run == '0)
		else $error("unconfigured outputs not static LVDS");
	a_unconf_type: assert property (@(posedge mclk) disable iff (!rst_n)
		!configured |-> out_lvpecl == '0 && out_run == '0)
		else $error("drive type set before first latch");
	a_unconf_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_UNCONF |=> !configured)
		else $error("configured flag raised early");
	a_type_map: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_CONF |=> out_lvpecl[`FOCP_BANK_A_W-1:0]
		== {`FOCP_BANK_A_W{$past(active_q.first_bank_drive_type)}})
		else $error("bank A drive type wrong");
	a_type_bcd: assert property (@(posedge mclk) disable iff (!rst_n)
		state_q == FOCP_CONF |=> out_lvpecl[`FOCP_OUT_N-1:`FOCP_BANK_A_W]
		== {(`FOCP_OUT_N-`FOCP_BANK_A_W){$past(active_q.bcd_banks_drive_type)}})
		else $error("banks B to D drive type wrong");

	// Latch and shift path
	a_latch_load: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise |=> active_q == $past(shift_q))
		else $error("latch missed word");
	a_latch_state: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise |=> state_q == FOCP_CONF)
		else $error("latch left port unconfigured");
	a_conf_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise |=> ##1 configured)
		else $error("configured flag not raised");
	a_hold_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
		!le_rise |=> $stable(active_q))
		else $error("config changed without latch");
	a_shift_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		sclk_rise && !le_lvl_q && !le_rise |=> active_q == $past(active_q))
		else $error("shifting disturbed active word");
	a_shift_in: assert property (@(posedge mclk) disable iff (!rst_n)
		sclk_rise && !le_lvl_q |=> shift_q[0] == $past(sdi_lvl_q))
		else $error("shift missed bit");
	a_shift_order: assert property (@(posedge mclk) disable iff (!rst_n)
		sclk_rise && !le_lvl_q |=>
		shift_q[`FOCP_WORD_W-1:1] == $past(shift_q[`FOCP_WORD_W-2:0]))
		else $error("shift order wrong");
	a_shift_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		!(sclk_rise && !le_lvl_q) |=> $stable(shift_q))
		else $error("shift register moved without a link clock");
	a_shift_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
		le_lvl_q |=> $stable(shift_q))
		else $error("shift register moved while strobe high");
	a_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> serial_out_line == $past(shift_q[`FOCP_WORD_W-1]))
		else $error("readback wrong");
endmodule // focp_port

// [testbench/focp_host_model.sv]
// Purpose: Host model driving the serial configuration link
// Assumes: Bit period 80 ns, data set 40 ns before each link clock rise
// Notes:   Link clock idles low; data returns to its pulled-down level
`timescale 1ns/1ps
module focp_host_model (
	output logic serial_clk,
	output logic serial_in_line,
	output logic config_latch_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_in_line = 1'b0;
		config_latch_strobe = 1'b0;
	end
	task automatic send_word(input logic [9:0] w, input logic latch);
		config_latch_strobe = 1'b0;
		for (int i = 9; i >= 0; i--) begin
			serial_in_line = w[i];
			#40 serial_clk = 1'b1;
			#40 serial_clk = 1'b0;
		end
		serial_in_line = 1'b0;
		#40 config_latch_strobe = latch;
	endtask
endmodule // focp_host_model

// [testbench/fanout_output_config_port_test.sv]
// Purpose: Self-checking bench for the fanout output configuration port
// Assumes: Outputs settle within 10 mclk after the last link activity
// Notes:   Expected notes hold {readback, configured, drive types, run enables}
`timescale 1ns/1ps
module fanout_output_config_port_test;
	import focp_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n;
	logic        global_oe;
	logic        serial_clk;
	logic        serial_in_line;
	logic        config_latch_strobe;
	logic        serial_out_line;
	logic        configured;
	logic [7:0]  out_run;
	logic [7:0]  out_lvpecl;
	logic [7:0]  lfsr_q;
	logic [17:0] note_q[$];
	int          num_errors = 0;
	int          num_checks = 0;
	event        check_ev;
	focp_port focp_port_inst (.mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk),
		.serial_in_line(serial_in_line), .config_latch_strobe(config_latch_strobe),
		.global_oe(global_oe), .serial_out_line(serial_out_line), .out_run(out_run),
		.out_lvpecl(out_lvpecl), .configured(configured));
	focp_host_model focp_host_model_inst (.serial_clk(serial_clk),
		.serial_in_line(serial_in_line), .config_latch_strobe(config_latch_strobe));
	always #5 mclk = ~mclk;
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [17:0] note(input logic [9:0] s, input logic [9:0] a,
		input logic oe);
		return {s[9], 1'b1, {6{a[1]}}, {2{a[0]}}, a[9:2] & {8{oe}}};
	endfunction
	task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic cmp1(input string name, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", name, e, g);
		end
	endtask
	task automatic expect_now(input logic [17:0] n);
		note_q.push_back(n);
		repeat (10) @(posedge mclk);
		#1 -> check_ev;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(check_ev) begin : monitor
		logic [17:0] n;
		n = note_q.pop_front();
		cmp8("out_run", n[7:0], out_run);
		cmp8("out_lvpecl", n[15:8], out_lvpecl);
		cmp1("configured", n[16], configured);
		cmp1("serial_out_line", n[17], serial_out_line);
	end
	initial begin : main
		logic [9:0] w;
		logic [9:0] act;
		rst_n = 1'b0;
		global_oe = 1'b0;
		lfsr_q = 8'h26;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		note_q.push_back(18'h00000);
		repeat (10) @(posedge mclk);
		#1 -> check_ev;
		$display("test reset state done");
		for (int t = 0; t < 4; t++) begin
			lfsr_q = lfsr_next(lfsr_q);
			w = {lfsr_q, t[1:0]};
			act = w;
			@(posedge mclk) #1 global_oe = 1'b1;
			focp_host_model_inst.send_word(w, 1'b1);
			expect_now(note(w, act, 1'b1));
			@(posedge mclk) #1 global_oe = 1'b0;
			expect_now(note(w, act, 1'b0));
			$display("test drive type %0d done", t);
		end
		@(posedge mclk) #1 global_oe = 1'b1;
		w = ~act;
		focp_host_model_inst.send_word(w, 1'b0);
		expect_now(note(w, act, 1'b1));
		$display("test shift without latch done");
		@(posedge mclk) #1 rst_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		expect_now(18'h00000);
		$display("test mid-run reset done");
		print_verdict();
	end
	initial begin : watchdog
		#50000;
		num_errors++;
		print_verdict();
	end
endmodule // fanout_output_config_port_test
